// ---- irq_latch_pkg.sv ----
/*
 * Constants for the interrupt mask and latch block: register offsets,
 * field positions, reset values, event-mode codes and pulse timing.
 * Assumes a 20 MHz system clock and an 8-bit register access port.
 */
package irq_latch_pkg;
   // Register port widths
   localparam int REG_AW = 8;
   localparam int REG_DW = 8;
   localparam int NUM_SRC = 5;

   // Register offsets
   localparam logic [7:0] ADDR_INT_CONFIG = 8'h32;
   localparam logic [7:0] ADDR_SOURCE_MASK = 8'h33;
   localparam logic [7:0] ADDR_LATCHED_STATUS = 8'h36;

   // Reset values
   localparam logic [7:0] RST_SOURCE_MASK = 8'hFF;
   localparam logic [4:0] RST_LATCHED = 5'h00;
   localparam logic [1:0] RST_EVENT_MODE = 2'h0;
   localparam logic RST_POLARITY = 1'b0;
   localparam logic RST_FILTER = 1'b0;
   localparam logic [7:0] READ_NONE = 8'h00;

   // Field positions
   localparam int SRC_LSB = 3;
   localparam int SRC_MSB = 7;
   localparam int CFG_POL_BIT = 7;
   localparam int CFG_MODE_LSB = 5;
   localparam int CFG_MODE_MSB = 6;
   localparam int CFG_FILTER_BIT = 2;
   localparam logic [2:0] RSVD_LOW_ZERO = 3'h0;

   // Event-mode codes
   localparam logic [1:0] MODE_LEVEL = 2'h0;
   localparam logic [1:0] MODE_PERIODIC = 2'h2;
   localparam logic [1:0] MODE_ONESHOT = 2'h3;

   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int IRQ_PULSE_US = 2000;
   localparam int IRQ_PERIOD_US = 4000;
   localparam int PULSE_CYCLES = IRQ_PULSE_US * (CLK_HZ / 1_000_000);
   localparam int PERIOD_CYCLES = IRQ_PERIOD_US * (CLK_HZ / 1_000_000);

   // Output timer states
   typedef enum logic [2:0] {
      T_IDLE = 3'b001,
      T_HIGH = 3'b010,
      T_LOW = 3'b100
   } timer_state_t;
endpackage

// ---- irq_timer_if.sv ----
/*
 * Link between the latch logic and the interrupt output timer.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
interface irq_timer_if;
   logic [1:0] mode;
   logic level;
   logic trigger;
   logic active;

   modport ctrl (output mode, output level, output trigger, input active);
   modport timer (input mode, input level, input trigger, output active);
endinterface

// ---- irq_pulse_timer.sv ----
/*
 * Interrupt output shaping: level, periodic 2 ms in 4 ms, or one 2 ms
 * pulse per event. Assumes mode, level and trigger come from the latch
 * logic on the same clock.
 */
`timescale 1ns/100ps
module irq_pulse_timer
#(
   parameter int PULSE_CYCLES = irq_latch_pkg::PULSE_CYCLES,
   parameter int PERIOD_CYCLES = irq_latch_pkg::PERIOD_CYCLES
)
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // Timer link
   irq_timer_if.timer tmr
);
   import irq_latch_pkg::*;

   localparam int CW = $clog2(PERIOD_CYCLES + 1);
   localparam logic [CW-1:0] PULSE_END = CW'(PULSE_CYCLES - 1);
   localparam logic [CW-1:0] PERIOD_END = CW'(PERIOD_CYCLES - 1);
   localparam logic [CW-1:0] CNT_ZERO = '0;

   timer_state_t state_reg;
   timer_state_t state_next;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;

   ////////////////////////////////////////////////////////////////////
   // Next state
   wire periodic = (tmr.mode == MODE_PERIODIC);
   wire oneshot = (tmr.mode == MODE_ONESHOT);
   wire pulse_done = (cnt_reg == PULSE_END);
   wire period_done = (cnt_reg == PERIOD_END);

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg + CW'(1);
      unique case (state_reg)
         T_IDLE:
         begin
            cnt_next = CNT_ZERO;
            if ((periodic && tmr.level) || (oneshot && tmr.trigger))
               state_next = T_HIGH;
         end
         T_HIGH:
         begin
            if (pulse_done)
               state_next = oneshot ? T_IDLE : T_LOW;
            if (!periodic && !oneshot)
               state_next = T_IDLE;
            if (periodic && !tmr.level)
               state_next = T_IDLE;
         end
         T_LOW:
         begin
            if (period_done)
            begin
               cnt_next = CNT_ZERO;
               state_next = T_HIGH;
            end
            if (!periodic || !tmr.level)
               state_next = T_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_reg <= T_IDLE;
         cnt_reg <= CNT_ZERO;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign tmr.active = (tmr.mode == MODE_LEVEL) ? tmr.level :
                       (state_reg == T_HIGH);

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_pulse_end;
      state_reg == T_HIGH && pulse_done && oneshot;
   endsequence

   a_pulse_width_max: assert property (
      state_reg == T_HIGH |-> cnt_reg <= PULSE_END)
      else $error("pulse longer than 2 ms");
   a_oneshot_ends: assert property (
      s_pulse_end |=> state_reg == T_IDLE && !tmr.active)
      else $error("one-shot pulse did not end");
   a_period_restart: assert property (
      state_reg == T_LOW && period_done && periodic && tmr.level
      |=> state_reg == T_HIGH && cnt_reg == CNT_ZERO)
      else $error("periodic pulse did not restart at 4 ms");
endmodule

// ---- irq_mask_latch.sv ----
/*
 * Interrupt mask, latch and configuration registers with the interrupt
 * output pin. Assumes single-cycle register strobes on the system clock
 * from the control port, and one-cycle event pulses from the sources.
 */
// Notes on behaviour
// - The mask register resets to all ones so every source starts masked.
// - Mask bit 7 masks the serial audio port clock error source.
// - Mask bit 6 masks the PLL lock source.
// - Mask bit 5 masks the serial input mixing saturation source.
// - Mask bit 4 masks the voice activity power-up source.
// - Mask bit 3 masks the voice activity power-down source.
// - The latched status register is read-only, resets to zero, bits 2-0 read zero.
// - Status bit 7 latches a serial audio port clock error and self-clears.
// - Status bit 6 latches a PLL lock event and self-clears.
// - Status bit 5 latches a mixing saturation alert and self-clears.
// - Status bit 4 latches voice activity power-up and self-clears.
// - Status bit 3 latches voice activity power-down and self-clears.
// - The readback filter select shows all events when clear, only unmasked when set.
// - The polarity bit makes the interrupt pin active low at 0, active high at 1.
// - Event mode 0 is level, 2 pulses 2 ms every 4 ms, 3 gives one 2 ms pulse per event.
`timescale 1ns/100ps
module irq_mask_latch
#(
   parameter int PULSE_CYCLES = irq_latch_pkg::PULSE_CYCLES,
   parameter int PERIOD_CYCLES = irq_latch_pkg::PERIOD_CYCLES
)
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [irq_latch_pkg::REG_AW-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [irq_latch_pkg::REG_DW-1:0] reg_wdata_i,
   output logic [irq_latch_pkg::REG_DW-1:0] reg_rdata_o,
   // Event pulses: 4 clock error, 3 PLL lock, 2 saturation, 1/0 voice
   input wire logic [irq_latch_pkg::NUM_SRC-1:0] event_pulses_i,
   // Interrupt pin
   output logic irq_pin_o
);
   import irq_latch_pkg::*;

   logic [REG_DW-1:0] mask_reg;
   logic [NUM_SRC-1:0] latch_reg;
   logic [NUM_SRC-1:0] latch_next;
   logic polarity_reg;
   logic [1:0] mode_reg;
   logic filter_reg;
   logic [REG_DW-1:0] rdata_next;

   irq_timer_if tmr ();

   function automatic logic [REG_DW-1:0] place_src(
      input logic [NUM_SRC-1:0] bits);
      place_src = {bits, RSVD_LOW_ZERO};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Decode
   wire cfg_wr = reg_wr_i && (reg_addr_i == ADDR_INT_CONFIG);
   wire mask_wr = reg_wr_i && (reg_addr_i == ADDR_SOURCE_MASK);
   wire stat_rd = reg_rd_i && (reg_addr_i == ADDR_LATCHED_STATUS);
   wire [NUM_SRC-1:0] src_mask = mask_reg[SRC_MSB:SRC_LSB];
   wire [NUM_SRC-1:0] unmasked = latch_reg & ~src_mask;
   wire [NUM_SRC-1:0] shown = filter_reg ? unmasked : latch_reg;
   wire [REG_DW-1:0] cfg_view = {polarity_reg, mode_reg, 2'h0,
                                 filter_reg, 2'h0};

   ////////////////////////////////////////////////////////////////////
   // Latches: set wins over the read clear
   assign latch_next = stat_rd ? event_pulses_i
                               : (latch_reg | event_pulses_i);

   always_comb
   begin
      rdata_next = READ_NONE;
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            ADDR_INT_CONFIG: rdata_next = cfg_view;
            ADDR_SOURCE_MASK: rdata_next = mask_reg;
            ADDR_LATCHED_STATUS: rdata_next = place_src(shown);
            default: rdata_next = READ_NONE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         mask_reg <= RST_SOURCE_MASK;
         latch_reg <= RST_LATCHED;
         polarity_reg <= RST_POLARITY;
         mode_reg <= RST_EVENT_MODE;
         filter_reg <= RST_FILTER;
         reg_rdata_o <= READ_NONE;
      end
      else
      begin
         if (mask_wr)
            mask_reg <= reg_wdata_i;
         if (cfg_wr)
         begin
            polarity_reg <= reg_wdata_i[CFG_POL_BIT];
            mode_reg <= reg_wdata_i[CFG_MODE_MSB:CFG_MODE_LSB];
            filter_reg <= reg_wdata_i[CFG_FILTER_BIT];
         end
         latch_reg <= latch_next;
         reg_rdata_o <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt output
   assign tmr.mode = mode_reg;
   assign tmr.level = |unmasked;
   assign tmr.trigger = |(event_pulses_i & ~src_mask);

   irq_pulse_timer #(
      .PULSE_CYCLES(PULSE_CYCLES),
      .PERIOD_CYCLES(PERIOD_CYCLES)
   ) u_timer (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .tmr(tmr.timer)
   );

   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         irq_pin_o <= !RST_POLARITY;
      else
         irq_pin_o <= polarity_reg ? tmr.active : !tmr.active;
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_low_active_level;
      mode_reg == MODE_LEVEL && tmr.level && !polarity_reg;
   endsequence

   sequence s_high_active_level;
      mode_reg == MODE_LEVEL && tmr.level && polarity_reg;
   endsequence

   sequence s_level_idle;
      mode_reg == MODE_LEVEL && !tmr.level && $stable(polarity_reg);
   endsequence

   a_mask_write: assert property (
      mask_wr |=> mask_reg == $past(reg_wdata_i))
      else $error("mask write not stored");
   a_mask_hold: assert property (
      !mask_wr |=> $stable(mask_reg))
      else $error("mask changed without a write");
   a_mask_clk_err: assert property (
      event_pulses_i[4] && !mask_reg[7] |=> tmr.level)
      else $error("unmasked clock error gave no interrupt");
   a_mask_pll: assert property (
      event_pulses_i[3] && !mask_reg[6] |=> tmr.level)
      else $error("unmasked PLL lock gave no interrupt");
   a_mask_sat: assert property (
      event_pulses_i[2] && !mask_reg[5] |=> tmr.level)
      else $error("unmasked saturation gave no interrupt");
   a_mask_vad_up: assert property (
      event_pulses_i[1] && !mask_reg[4] |=> tmr.level)
      else $error("unmasked voice power-up gave no interrupt");
   a_mask_vad_down: assert property (
      event_pulses_i[0] && !mask_reg[3] |=> tmr.level)
      else $error("unmasked voice power-down gave no interrupt");
   a_status_low_zero: assert property (
      stat_rd |=> reg_rdata_o[SRC_LSB-1:0] == RSVD_LOW_ZERO)
      else $error("reserved status bits not zero");
   a_latch_capture: assert property (
      event_pulses_i != '0 |=>
      (latch_reg & $past(event_pulses_i)) == $past(event_pulses_i))
      else $error("event not latched");
   a_read_clears: assert property (
      stat_rd |=> latch_reg == $past(event_pulses_i))
      else $error("status read did not clear latches");
   a_filter_masked: assert property (
      stat_rd && filter_reg |=>
      (reg_rdata_o & $past(mask_reg)) == READ_NONE)
      else $error("masked event visible with filter set");
   a_pin_low_active: assert property (
      s_low_active_level ##1 s_low_active_level |-> !irq_pin_o)
      else $error("active-low interrupt pin not low");
   a_pin_high_active: assert property (
      s_high_active_level ##1 s_high_active_level |-> irq_pin_o)
      else $error("active-high interrupt pin not high");
   a_pin_idle_level: assert property (
      s_level_idle ##1 s_level_idle |-> irq_pin_o == !polarity_reg)
      else $error("interrupt pin active with no unmasked event");
   a_cfg_write: assert property (
      cfg_wr |=> polarity_reg == $past(reg_wdata_i[CFG_POL_BIT]) &&
      mode_reg == $past(reg_wdata_i[CFG_MODE_MSB:CFG_MODE_LSB]) &&
      filter_reg == $past(reg_wdata_i[CFG_FILTER_BIT]))
      else $error("config write not stored");
   a_status_view: assert property (
      stat_rd && !filter_reg |=>
      reg_rdata_o == {$past(latch_reg), RSVD_LOW_ZERO})
      else $error("status read shows wrong bits");
   a_status_filtered: assert property (
      stat_rd && filter_reg |=>
      reg_rdata_o[SRC_MSB:SRC_LSB] == ($past(latch_reg) & ~$past(src_mask)))
      else $error("filtered status shows wrong bits");
   a_status_read_only: assert property (
      reg_wr_i && reg_addr_i == ADDR_LATCHED_STATUS && !reg_rd_i |=>
      latch_reg == ($past(latch_reg) | $past(event_pulses_i)))
      else $error("status register changed by a write");
   a_latch_hold: assert property (
      !stat_rd && event_pulses_i == '0 |=> $stable(latch_reg))
      else $error("latch changed without event or read");
   a_reserved_mask: assert property (
      mask_wr |=> mask_reg[SRC_LSB-1:0] == $past(reg_wdata_i[SRC_LSB-1:0]))
      else $error("reserved mask bits not stored");
endmodule

// ---- host_port_model.sv ----
/*
 * Host processor on the control port: single-byte register writes and
 * reads. Assumes the device samples its strobes on the rising edge.
 */
`timescale 1ns/100ps
module host_port_model
(
   // Clock
   input wire logic clk_i,
   // Register port
   output logic [7:0] addr_o,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i
);
   initial
   begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus cycles
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask
endmodule

// ---- testbench.sv ----
/*
 * Self-checking bench for the interrupt mask and latch block.
 * Assumes shortened pulse timing: 4 cycles high in an 8-cycle period.
 */
`timescale 1ns/100ps
module testbench;
   import irq_latch_pkg::*;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [4:0] ev = 5'h00;
   logic irq_pin_o;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] d;
   logic reg_wr;
   logic reg_rd;
   int error_cnt = 0;
   int samples_checked = 0;
   int cnt;

   always #25 clk_sys_i = ~clk_sys_i;

   irq_mask_latch #(.PULSE_CYCLES(4), .PERIOD_CYCLES(8)) dut (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
      .event_pulses_i(ev), .irq_pin_o(irq_pin_o));

   host_port_model host (
      .clk_i(clk_sys_i), .addr_o(reg_addr), .wr_o(reg_wr),
      .rd_o(reg_rd), .wdata_o(reg_wdata), .rdata_i(reg_rdata));

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic chk(input logic [7:0] g, input logic [7:0] e,
                      input string w);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                         input string w);
      logic [7:0] v;
      host.rd_reg(a, v);
      chk(v, e, w);
   endtask

   task automatic pulse(input logic [4:0] b);
      @(posedge clk_sys_i);
      ev <= b;
      @(posedge clk_sys_i);
      ev <= 5'h00;
   endtask

   task automatic count_pin(input int n, input logic lvl, output int c);
      c = 0;
      repeat (n)
      begin
         @(posedge clk_sys_i);
         #1;
         if (irq_pin_o === lvl)
            c++;
      end
   endtask

   task automatic wait_pin(input logic lvl);
      int k;
      k = 0;
      while (irq_pin_o !== lvl && k < 20)
      begin
         @(posedge clk_sys_i);
         #1;
         k++;
      end
      chk({7'h00, irq_pin_o}, {7'h00, lvl}, "pin level");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      rd_chk(ADDR_SOURCE_MASK, 8'hFF, "mask reset");
      rd_chk(ADDR_LATCHED_STATUS, 8'h00, "status reset");
      rd_chk(8'h40, 8'h00, "unmapped read");
      chk({7'h00, irq_pin_o}, 8'h01, "pin idle");
      $display("test reset done");
   endtask

   task automatic t_latch;
      for (int i = 0; i < 5; i++)
      begin
         pulse(5'h01 << i);
         rd_chk(ADDR_LATCHED_STATUS, 8'h08 << i, "latch");
         rd_chk(ADDR_LATCHED_STATUS, 8'h00, "self clear");
      end
      chk({7'h00, irq_pin_o}, 8'h01, "masked pin");
      fork
         pulse(5'h01);
         host.rd_reg(ADDR_LATCHED_STATUS, d);
      join
      rd_chk(ADDR_LATCHED_STATUS, 8'h08, "set wins");
      host.wr_reg(ADDR_LATCHED_STATUS, 8'hFF);
      rd_chk(ADDR_LATCHED_STATUS, 8'h00, "status ro");
      $display("test latch done");
   endtask

   task automatic t_level;
      for (int i = 0; i < 5; i++)
      begin
         host.wr_reg(ADDR_SOURCE_MASK, ~(8'h08 << i));
         pulse(5'h01 << ((i + 1) % 5));
         count_pin(4, 1'b0, cnt);
         chk(cnt[7:0], 8'h00, "masked quiet");
         host.rd_reg(ADDR_LATCHED_STATUS, d);
         pulse(5'h01 << i);
         wait_pin(1'b0);
         rd_chk(ADDR_LATCHED_STATUS, 8'h08 << i, "level latch");
         wait_pin(1'b1);
      end
      $display("test level done");
   endtask

   task automatic t_filter;
      host.wr_reg(ADDR_SOURCE_MASK, 8'hF0);
      rd_chk(ADDR_SOURCE_MASK, 8'hF0, "mask rw");
      pulse(5'h11);
      rd_chk(ADDR_LATCHED_STATUS, 8'h88, "filter off");
      host.wr_reg(ADDR_INT_CONFIG, 8'h1F);
      rd_chk(ADDR_INT_CONFIG, 8'h04, "config rw");
      pulse(5'h11);
      rd_chk(ADDR_LATCHED_STATUS, 8'h08, "filter on");
      host.wr_reg(ADDR_INT_CONFIG, 8'h80);
      host.rd_reg(ADDR_LATCHED_STATUS, d);
      wait_pin(1'b0);
      pulse(5'h01);
      wait_pin(1'b1);
      host.rd_reg(ADDR_LATCHED_STATUS, d);
      wait_pin(1'b0);
      $display("test filter and polarity done");
   endtask

   task automatic t_modes;
      host.wr_reg(ADDR_SOURCE_MASK, 8'h7F);
      host.wr_reg(ADDR_INT_CONFIG, 8'hC0);
      pulse(5'h10);
      wait_pin(1'b1);
      count_pin(16, 1'b1, cnt);
      chk(cnt[7:0], 8'h08, "periodic");
      host.rd_reg(ADDR_LATCHED_STATUS, d);
      count_pin(10, 1'b1, cnt);
      count_pin(8, 1'b1, cnt);
      chk(cnt[7:0], 8'h00, "periodic stop");
      host.wr_reg(ADDR_INT_CONFIG, 8'hE0);
      pulse(5'h10);
      wait_pin(1'b1);
      count_pin(12, 1'b1, cnt);
      chk(cnt[7:0], 8'h03, "one shot");
      rd_chk(ADDR_LATCHED_STATUS, 8'h80, "one shot latch");
      host.wr_reg(ADDR_INT_CONFIG, 8'hA0);
      pulse(5'h10);
      count_pin(6, 1'b1, cnt);
      chk(cnt[7:0], 8'h00, "unused mode");
      host.rd_reg(ADDR_LATCHED_STATUS, d);
      $display("test modes done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Run control
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      t_reset;
      t_latch;
      t_level;
      t_filter;
      t_modes;
      end_of_test;
   end

   initial
   begin
      #200000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test;
   end
endmodule
